/* src/usb_ctrl_endpoint_txn_control.sv */
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module usb_ctrl_endpoint_txn_control (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic tok_valid,
  input wire logic [1:0] tok_kind,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_pid_toggle,
  input wire logic rx_end,
  input wire logic rx_err,
  output logic hs_valid,
  output logic [1:0] hs_code,
  output logic tx_start,
  output logic [6:0] tx_len,
  output logic tx_toggle,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic host_ack,
  input wire logic host_timeout,
  input wire logic [6:0] fifo_count,
  input wire logic [6:0] fifo_free,
  input wire logic [5:0] fifo_rd_head,
  output logic [11:0] fifo_rd_addr,
  input wire logic [7:0] fifo_rd_data,
  output logic fifo_rd_commit,
  output logic [6:0] fifo_rd_bytes,
  output logic fifo_wr_en,
  output logic [7:0] fifo_wr_data,
  output logic fifo_wr_commit,
  output logic fifo_wr_abort,
  output logic event_irq
);

  typedef struct packed {
    usb_ctrl_ep_pkg::state_e st;
    logic dir_in;
    logic desc_en;
    logic from_desc;
    logic guard;
    logic setup_flag;
    logic [6:0] ep_flags;
    logic desc_done;
    logic [1:0] tog;
    logic [1:0] nak;
    logic [1:0] stall;
    logic short_allow;
    logic auto_nak;
    logic [11:0] desc_ptr;
    logic [11:0] desc_len;
    logic [63:0] setup_data;
    logic [6:0] cnt;
    logic [6:0] len;
    logic [5:0] head;
    logic [7:0] rdata;
    logic hs_valid;
    logic [1:0] hs_code;
    logic wr_en;
    logic [7:0] wr_data;
    logic wr_commit;
    logic wr_abort;
    logic tx_start;
    logic tx_valid;
    logic [7:0] tx_data;
    logic rd_commit;
    logic [6:0] rd_bytes;
  } state_s;

  state_s q;
  state_s d;
  logic [5:0] ring_addr;

  // The normal IN path wraps inside the 64-byte region at location zero.
  assign ring_addr = q.head + q.cnt[5:0];
  assign fifo_rd_addr = q.from_desc ? q.desc_ptr + {5'h00, q.cnt}
                                    : {6'h00, ring_addr};

  assign reg_rdata = q.rdata;
  assign hs_valid = q.hs_valid;
  assign hs_code = q.hs_code;
  assign tx_start = q.tx_start;
  assign tx_len = q.len;
  assign tx_toggle = q.tog[usb_ctrl_ep_pkg::DIR_IN];
  assign tx_valid = q.tx_valid;
  assign tx_data = q.tx_data;
  assign fifo_rd_commit = q.rd_commit;
  assign fifo_rd_bytes = q.rd_bytes;
  assign fifo_wr_en = q.wr_en;
  assign fifo_wr_data = q.wr_data;
  assign fifo_wr_commit = q.wr_commit;
  assign fifo_wr_abort = q.wr_abort;
  // No mask here; any pending flag raises the event line.
  assign event_irq = q.setup_flag | (|q.ep_flags) | q.desc_done;

  always_comb begin
    d = q;
    d.hs_valid = 1'b0;
    d.wr_en = 1'b0;
    d.wr_commit = 1'b0;
    d.wr_abort = 1'b0;
    d.tx_start = 1'b0;
    d.rd_commit = 1'b0;
    d.rdata = 8'h00;

    if (reg_rd) begin
      unique case (reg_addr)
        usb_ctrl_ep_pkg::ADDR_MAIN_STAT: d.rdata = {7'h00, q.setup_flag};
        usb_ctrl_ep_pkg::ADDR_EP_STAT: d.rdata = {1'b0, q.ep_flags};
        usb_ctrl_ep_pkg::ADDR_FIFO_STAT: d.rdata = {7'h00, q.desc_done};
        usb_ctrl_ep_pkg::ADDR_EP_CTRL: d.rdata = {6'h00, q.desc_en, q.dir_in};
        usb_ctrl_ep_pkg::ADDR_IN_CTRL: begin
          d.rdata = {2'h0, q.short_allow, q.stall[usb_ctrl_ep_pkg::DIR_IN],
                     q.nak[usb_ctrl_ep_pkg::DIR_IN], 2'h0,
                     q.tog[usb_ctrl_ep_pkg::DIR_IN]};
        end
        usb_ctrl_ep_pkg::ADDR_OUT_CTRL: begin
          d.rdata = {1'b0, q.auto_nak, 1'b0,
                     q.stall[usb_ctrl_ep_pkg::DIR_OUT],
                     q.nak[usb_ctrl_ep_pkg::DIR_OUT], 2'h0,
                     q.tog[usb_ctrl_ep_pkg::DIR_OUT]};
        end
        usb_ctrl_ep_pkg::ADDR_SETUP_CTRL: d.rdata = {7'h00, q.guard};
        usb_ctrl_ep_pkg::ADDR_DESC_PTR_H: d.rdata = {4'h0, q.desc_ptr[11:8]};
        usb_ctrl_ep_pkg::ADDR_DESC_PTR_L: d.rdata = q.desc_ptr[7:0];
        usb_ctrl_ep_pkg::ADDR_DESC_LEN_H: d.rdata = {4'h0, q.desc_len[11:8]};
        usb_ctrl_ep_pkg::ADDR_DESC_LEN_L: d.rdata = q.desc_len[7:0];
        default: begin
          if (reg_addr[7:3] == usb_ctrl_ep_pkg::ADDR_SETUP_BASE) begin
            d.rdata = q.setup_data[reg_addr[2:0]*8 +: 8];
          end
        end
      endcase
    end

    // Software writes come first so that hardware events below win.
    if (reg_wr) begin
      unique case (reg_addr)
        usb_ctrl_ep_pkg::ADDR_MAIN_STAT: begin
          if (reg_wdata[usb_ctrl_ep_pkg::B_FLAG]) begin
            d.setup_flag = 1'b0;
          end
        end
        usb_ctrl_ep_pkg::ADDR_EP_STAT: begin
          d.ep_flags = q.ep_flags & ~reg_wdata[6:0];
        end
        usb_ctrl_ep_pkg::ADDR_FIFO_STAT: begin
          if (reg_wdata[usb_ctrl_ep_pkg::B_FLAG]) begin
            d.desc_done = 1'b0;
          end
        end
        usb_ctrl_ep_pkg::ADDR_EP_CTRL: begin
          d.dir_in = reg_wdata[usb_ctrl_ep_pkg::B_DIR_IN];
          d.desc_en = reg_wdata[usb_ctrl_ep_pkg::B_DESC_EN];
        end
        usb_ctrl_ep_pkg::ADDR_IN_CTRL: begin
          if (reg_wdata[usb_ctrl_ep_pkg::B_FORCE_ONE]) begin
            d.tog[usb_ctrl_ep_pkg::DIR_IN] = 1'b1;
          end
          if (reg_wdata[usb_ctrl_ep_pkg::B_FORCE_ZERO]) begin
            d.tog[usb_ctrl_ep_pkg::DIR_IN] = 1'b0;
          end
          if (!q.guard) begin
            d.nak[usb_ctrl_ep_pkg::DIR_IN] =
              reg_wdata[usb_ctrl_ep_pkg::B_NAK];
            d.stall[usb_ctrl_ep_pkg::DIR_IN] =
              reg_wdata[usb_ctrl_ep_pkg::B_STALL];
          end
          d.short_allow = reg_wdata[usb_ctrl_ep_pkg::B_SHORT];
        end
        usb_ctrl_ep_pkg::ADDR_OUT_CTRL: begin
          if (reg_wdata[usb_ctrl_ep_pkg::B_FORCE_ONE]) begin
            d.tog[usb_ctrl_ep_pkg::DIR_OUT] = 1'b1;
          end
          if (reg_wdata[usb_ctrl_ep_pkg::B_FORCE_ZERO]) begin
            d.tog[usb_ctrl_ep_pkg::DIR_OUT] = 1'b0;
          end
          if (!q.guard) begin
            d.nak[usb_ctrl_ep_pkg::DIR_OUT] =
              reg_wdata[usb_ctrl_ep_pkg::B_NAK];
            d.stall[usb_ctrl_ep_pkg::DIR_OUT] =
              reg_wdata[usb_ctrl_ep_pkg::B_STALL];
          end
          d.auto_nak = reg_wdata[usb_ctrl_ep_pkg::B_AUTO_NAK];
        end
        usb_ctrl_ep_pkg::ADDR_SETUP_CTRL: begin
          if (reg_wdata[usb_ctrl_ep_pkg::B_FLAG]) begin
            d.guard = 1'b0;
          end
        end
        usb_ctrl_ep_pkg::ADDR_DESC_PTR_H: d.desc_ptr[11:8] = reg_wdata[3:0];
        usb_ctrl_ep_pkg::ADDR_DESC_PTR_L: d.desc_ptr[7:0] = reg_wdata;
        usb_ctrl_ep_pkg::ADDR_DESC_LEN_H: d.desc_len[11:8] = reg_wdata[3:0];
        usb_ctrl_ep_pkg::ADDR_DESC_LEN_L: d.desc_len[7:0] = reg_wdata;
        default: begin
        end
      endcase
    end

    unique case (q.st)
      usb_ctrl_ep_pkg::ST_IDLE: begin
        if (tok_valid) begin
          d.cnt = 7'h00;
          unique case (usb_ctrl_ep_pkg::token_e'(tok_kind))
            usb_ctrl_ep_pkg::TOK_SETUP: d.st = usb_ctrl_ep_pkg::ST_SETUP_RX;
            usb_ctrl_ep_pkg::TOK_IN: begin
              d.hs_valid = 1'b1;
              d.hs_code = usb_ctrl_ep_pkg::HS_NAK;
              if (q.stall[usb_ctrl_ep_pkg::DIR_IN]) begin
                d.hs_code = usb_ctrl_ep_pkg::HS_STALL;
              end else if (q.nak[usb_ctrl_ep_pkg::DIR_IN] || !q.dir_in) begin
                d.ep_flags[usb_ctrl_ep_pkg::F_IN_NAK] = 1'b1;
              end else if (q.desc_en) begin
                d.hs_valid = 1'b0;
                d.from_desc = 1'b1;
                d.tx_start = 1'b1;
                d.len = (q.desc_len >= usb_ctrl_ep_pkg::MAX_PKT_W) ?
                        usb_ctrl_ep_pkg::MAX_PKT : q.desc_len[6:0];
                d.st = usb_ctrl_ep_pkg::ST_IN_LOAD;
              end else if (fifo_count >= usb_ctrl_ep_pkg::MAX_PKT ||
                           q.short_allow) begin
                d.hs_valid = 1'b0;
                d.from_desc = 1'b0;
                d.head = fifo_rd_head;
                d.tx_start = 1'b1;
                d.len = (fifo_count >= usb_ctrl_ep_pkg::MAX_PKT) ?
                        usb_ctrl_ep_pkg::MAX_PKT : fifo_count;
                d.st = usb_ctrl_ep_pkg::ST_IN_LOAD;
              end else begin
                d.ep_flags[usb_ctrl_ep_pkg::F_IN_NAK] = 1'b1;
              end
            end
            default: begin
              // OUT and PING share the OUT direction's holds and space test.
              d.hs_valid = 1'b1;
              d.hs_code = usb_ctrl_ep_pkg::HS_NAK;
              if (q.stall[usb_ctrl_ep_pkg::DIR_OUT]) begin
                d.hs_code = usb_ctrl_ep_pkg::HS_STALL;
              end else if (q.nak[usb_ctrl_ep_pkg::DIR_OUT] || q.dir_in ||
                           fifo_free < usb_ctrl_ep_pkg::MAX_PKT) begin
                d.ep_flags[usb_ctrl_ep_pkg::F_OUT_NAK] = 1'b1;
              end else if (tok_kind == usb_ctrl_ep_pkg::TOK_PING) begin
                d.hs_code = usb_ctrl_ep_pkg::HS_ACK;
              end else begin
                d.hs_valid = 1'b0;
                d.st = usb_ctrl_ep_pkg::ST_OUT_RX;
              end
            end
          endcase
        end
      end
      usb_ctrl_ep_pkg::ST_SETUP_RX: begin
        if (rx_err) begin
          d.st = usb_ctrl_ep_pkg::ST_IDLE;
        end else if (rx_end) begin
          d.st = usb_ctrl_ep_pkg::ST_IDLE;
          // A SETUP of any other length is treated as damaged: no answer.
          if (q.cnt == usb_ctrl_ep_pkg::SETUP_BYTES) begin
            d.hs_valid = 1'b1;
            d.hs_code = usb_ctrl_ep_pkg::HS_ACK;
            d.setup_flag = 1'b1;
            d.guard = 1'b1;
            d.nak = 2'h3;
            d.stall = 2'h0;
            d.tog = 2'h3;
          end
        end else if (rx_valid) begin
          if (q.cnt < usb_ctrl_ep_pkg::SETUP_BYTES) begin
            d.setup_data[q.cnt[2:0]*8 +: 8] = rx_data;
          end
          if (q.cnt <= usb_ctrl_ep_pkg::SETUP_BYTES) begin
            d.cnt = q.cnt + 7'h01;
          end
        end
      end
      usb_ctrl_ep_pkg::ST_OUT_RX: begin
        if (rx_err) begin
          d.wr_abort = 1'b1;
          d.ep_flags[usb_ctrl_ep_pkg::F_OUT_ERR] = 1'b1;
          d.st = usb_ctrl_ep_pkg::ST_IDLE;
        end else if (rx_end) begin
          d.st = usb_ctrl_ep_pkg::ST_IDLE;
          d.hs_valid = 1'b1;
          d.hs_code = usb_ctrl_ep_pkg::HS_ACK;
          // A repeated packet is acknowledged but neither stored nor reported.
          if (rx_pid_toggle == q.tog[usb_ctrl_ep_pkg::DIR_OUT]) begin
            d.wr_commit = 1'b1;
            d.tog[usb_ctrl_ep_pkg::DIR_OUT] = ~q.tog[usb_ctrl_ep_pkg::DIR_OUT];
            d.ep_flags[usb_ctrl_ep_pkg::F_OUT_ACK] = 1'b1;
            if (q.cnt < usb_ctrl_ep_pkg::MAX_PKT) begin
              d.ep_flags[usb_ctrl_ep_pkg::F_OUT_SHORT] = 1'b1;
            end
            if (q.auto_nak) begin
              d.nak[usb_ctrl_ep_pkg::DIR_OUT] = 1'b1;
            end
          end else begin
            d.wr_abort = 1'b1;
          end
        end else if (rx_valid && q.cnt < usb_ctrl_ep_pkg::MAX_PKT) begin
          d.wr_en = 1'b1;
          d.wr_data = rx_data;
          d.cnt = q.cnt + 7'h01;
        end
      end
      usb_ctrl_ep_pkg::ST_IN_LOAD: begin
        if (q.len == 7'h00) begin
          d.st = usb_ctrl_ep_pkg::ST_IN_WAIT;
        end else begin
          d.tx_data = fifo_rd_data;
          d.tx_valid = 1'b1;
          d.cnt = 7'h01;
          d.st = usb_ctrl_ep_pkg::ST_IN_SEND;
        end
      end
      usb_ctrl_ep_pkg::ST_IN_SEND: begin
        if (tx_ready) begin
          if (q.cnt == q.len) begin
            d.tx_valid = 1'b0;
            d.st = usb_ctrl_ep_pkg::ST_IN_WAIT;
          end else begin
            d.tx_data = fifo_rd_data;
            d.cnt = q.cnt + 7'h01;
          end
        end
      end
      usb_ctrl_ep_pkg::ST_IN_WAIT: begin
        if (host_ack) begin
          d.st = usb_ctrl_ep_pkg::ST_IDLE;
          d.tog[usb_ctrl_ep_pkg::DIR_IN] = ~q.tog[usb_ctrl_ep_pkg::DIR_IN];
          d.ep_flags[usb_ctrl_ep_pkg::F_IN_ACK] = 1'b1;
          if (q.len < usb_ctrl_ep_pkg::MAX_PKT) begin
            d.short_allow = 1'b0;
          end
          if (q.from_desc) begin
            d.desc_ptr = q.desc_ptr + {5'h00, q.len};
            d.desc_len = q.desc_len - {5'h00, q.len};
            if (q.desc_len == {5'h00, q.len}) begin
              d.desc_en = 1'b0;
              d.desc_done = 1'b1;
            end
          end else begin
            d.rd_commit = 1'b1;
            d.rd_bytes = q.len;
          end
        end else if (host_timeout) begin
          d.st = usb_ctrl_ep_pkg::ST_IDLE;
          d.ep_flags[usb_ctrl_ep_pkg::F_IN_ERR] = 1'b1;
        end
      end
      default: d.st = usb_ctrl_ep_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : usb_ctrl_endpoint_txn_control

/* inc/usb_ctrl_ep_pkg.sv */
// Summary of operation
// - Token answers are decided from FIFO byte count or free space.
// - Results other than STALL, PING ACK, repeated OUT and damaged SETUP set a status flag that drives the event output.
// - One direction bit selects IN or OUT for data and status stages.
// - Descriptor reply enable starts an automatic descriptor answer.
// - The descriptor answer starts at the programmed two-part FIFO pointer.
// - The descriptor answer returns exactly the programmed two-part byte length.
// - End of the descriptor data stage sets the descriptor done flag.
// - While the guard bit is set, NAK and STALL hold bit writes are ignored.
// - Hardware sets the guard with the setup flag; only a CPU write clears it.
// - Short packet allow permits short INs and clears after one completes.
// - Each direction keeps a readable toggle, reinitialised by SETUP.
// - Writing toggle force one sets that direction's toggle to one.
// - Writing toggle force zero sets that direction's toggle to zero.
// - NAK hold makes every IN, OUT or PING in that direction get NAK unless STALL hold is also set.
// - STALL hold makes IN, OUT or PING in that direction get STALL.
// - Auto NAK hold sets the OUT NAK hold bit after each completed OUT.
// - An executed SETUP sets the setup received flag.
// - Outcomes use separate ACK, NAK and error flags per direction, and a short ACK flag for OUT only.
// - SETUP completion sets NAK holds, clears STALL holds, sets toggles, guard.
// - All eight SETUP bytes are captured in registers before ACK.
// - The normal IN path uses a 64-byte FIFO region from location zero; descriptor reads follow the 12-bit pointer.
package usb_ctrl_ep_pkg;
  localparam int FIFO_AW = 12;
  localparam logic [6:0] MAX_PKT = 7'h40;
  localparam logic [11:0] MAX_PKT_W = 12'h040;
  localparam logic [6:0] SETUP_BYTES = 7'h08;

  typedef enum logic [1:0] {
    TOK_SETUP = 2'b00,
    TOK_OUT = 2'b01,
    TOK_IN = 2'b10,
    TOK_PING = 2'b11
  } token_e;
  typedef enum logic [1:0] {
    HS_ACK = 2'b00,
    HS_NAK = 2'b01,
    HS_STALL = 2'b10
  } handshake_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP_RX = 3'b001,
    ST_OUT_RX = 3'b010,
    ST_IN_LOAD = 3'b011,
    ST_IN_SEND = 3'b100,
    ST_IN_WAIT = 3'b101
  } state_e;
  localparam logic [7:0] ADDR_MAIN_STAT = 8'h00;
  localparam logic [7:0] ADDR_EP_STAT = 8'h01;
  localparam logic [7:0] ADDR_FIFO_STAT = 8'h02;
  localparam logic [7:0] ADDR_EP_CTRL = 8'h03;
  localparam logic [7:0] ADDR_IN_CTRL = 8'h04;
  localparam logic [7:0] ADDR_OUT_CTRL = 8'h05;
  localparam logic [7:0] ADDR_SETUP_CTRL = 8'h06;
  localparam logic [7:0] ADDR_DESC_PTR_H = 8'h07;
  localparam logic [7:0] ADDR_DESC_PTR_L = 8'h08;
  localparam logic [7:0] ADDR_DESC_LEN_H = 8'h09;
  localparam logic [7:0] ADDR_DESC_LEN_L = 8'h0a;
  localparam logic [4:0] ADDR_SETUP_BASE = 5'h02;

  // Per-direction index: 0 is OUT, 1 is IN.
  localparam int DIR_OUT = 0;
  localparam int DIR_IN = 1;

  // Endpoint status flag positions.
  localparam int F_OUT_ERR = 0;
  localparam int F_IN_ERR = 1;
  localparam int F_OUT_NAK = 2;
  localparam int F_IN_NAK = 3;
  localparam int F_OUT_ACK = 4;
  localparam int F_IN_ACK = 5;
  localparam int F_OUT_SHORT = 6;

  // Control register bit positions.
  localparam int B_DIR_IN = 0;
  localparam int B_DESC_EN = 1;
  localparam int B_TOGGLE = 0;
  localparam int B_FORCE_ONE = 1;
  localparam int B_FORCE_ZERO = 2;
  localparam int B_NAK = 3;
  localparam int B_STALL = 4;
  localparam int B_SHORT = 5;
  localparam int B_AUTO_NAK = 6;
  localparam int B_FLAG = 0;

endpackage : usb_ctrl_ep_pkg

/* test/usb_ctrl_ep_chk.sv */
`timescale 1ns/1ps
module usb_ctrl_ep_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tok_valid,
  input wire logic [1:0] tok_kind,
  input wire logic rx_valid,
  input wire logic rx_err,
  input wire logic hs_valid,
  input wire logic [1:0] hs_code,
  input wire logic tx_start,
  input wire logic [6:0] tx_len,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic fifo_wr_en,
  input wire logic fifo_wr_commit,
  input wire logic fifo_wr_abort,
  input wire logic event_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_quiet2;
    !hs_valid ##1 !hs_valid;
  endsequence
  sequence s_in_tok;
    tok_valid && tok_kind == usb_ctrl_ep_pkg::TOK_IN;
  endsequence
  sequence s_ping_tok;
    tok_valid && tok_kind == usb_ctrl_ep_pkg::TOK_PING;
  endsequence

  property p_nak_flag;
    hs_valid && hs_code == usb_ctrl_ep_pkg::HS_NAK |-> ##[0:1] event_irq;
  endproperty
  property p_len_cap;
    tx_start |-> tx_len <= usb_ctrl_ep_pkg::MAX_PKT;
  endproperty
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  property p_commit_ack;
    fifo_wr_commit |-> hs_valid && !fifo_wr_abort
      && hs_code == usb_ctrl_ep_pkg::HS_ACK;
  endproperty
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  property p_ping_answer;
    s_ping_tok |=> hs_valid;
  endproperty
  property p_err_silent;
    rx_err |=> s_quiet2;
  endproperty
  property p_wr_src;
    fifo_wr_en |-> $past(rx_valid);
  endproperty
  property p_in_answer;
    s_in_tok |=> tx_start || hs_valid;
  endproperty

  a_nak_flag: assert property (p_nak_flag)
    else $error("NAK answered without a status flag");
  a_len_cap: assert property (p_len_cap)
    else $error("IN packet longer than the endpoint region");
  a_tx_hold: assert property (p_tx_hold)
    else $error("IN byte dropped or changed while stalled");
  a_commit_ack: assert property (p_commit_ack)
    else $error("OUT commit without ACK handshake");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside the read answer cycle");
  a_ping_answer: assert property (p_ping_answer)
    else $error("PING left unanswered");
  a_err_silent: assert property (p_err_silent)
    else $error("handshake sent for a damaged packet");
  a_wr_src: assert property (p_wr_src)
    else $error("FIFO write without a received byte");
  a_in_answer: assert property (p_in_answer)
    else $error("IN token neither answered nor started");
endmodule : usb_ctrl_ep_chk

bind usb_ctrl_endpoint_txn_control usb_ctrl_ep_chk u_usb_ctrl_ep_chk (
  .sys_clk(sys_clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tok_valid(tok_valid), .tok_kind(tok_kind), .rx_valid(rx_valid),
  .rx_err(rx_err), .hs_valid(hs_valid), .hs_code(hs_code),
  .tx_start(tx_start), .tx_len(tx_len), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .fifo_wr_en(fifo_wr_en),
  .fifo_wr_commit(fifo_wr_commit), .fifo_wr_abort(fifo_wr_abort),
  .event_irq(event_irq));

/* test/usb_host_model.sv */
`timescale 1ns/1ps
module usb_host_model (
  input wire logic sys_clk,
  input wire logic slow,
  output logic tok_valid,
  output logic [1:0] tok_kind,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_pid_toggle,
  output logic rx_end,
  output logic rx_err,
  output logic tx_ready,
  output logic host_ack,
  output logic host_timeout
);
  initial {tok_valid, tok_kind, rx_valid, rx_data, rx_pid_toggle} = '0;
  initial {rx_end, rx_err, tx_ready, host_ack, host_timeout} = '0;

  // A slow host takes every other byte, so the block must hold its data.
  always @(posedge sys_clk) tx_ready <= slow ? ~tx_ready : 1'b1;

  task token(input logic [1:0] k);
    @(posedge sys_clk);
    tok_valid <= 1'b1;
    tok_kind <= k;
    @(posedge sys_clk);
    tok_valid <= 1'b0;
    tok_kind <= ~k;
  endtask : token

  task packet(input int n, input logic tog, input logic bad);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_data <= 8'ha0 + 8'(i);
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_pid_toggle <= tog;
    rx_end <= ~bad;
    rx_err <= bad;
    @(posedge sys_clk);
    rx_end <= 1'b0;
    rx_err <= 1'b0;
  endtask : packet

  task answer(input logic ok);
    @(posedge sys_clk);
    host_ack <= ok;
    host_timeout <= ~ok;
    @(posedge sys_clk);
    host_ack <= 1'b0;
    host_timeout <= 1'b0;
  endtask : answer
endmodule : usb_host_model

/* test/test_usb_ctrl_endpoint_txn_control.sv */
`timescale 1ns/1ps
module test_usb_ctrl_endpoint_txn_control;
  logic sys_clk, rst, reg_wr, reg_rd, tok_valid, rx_valid, rx_pid_toggle;
  logic rx_end, rx_err, hs_valid, tx_start, tx_toggle, tx_valid, tx_ready;
  logic host_ack, host_timeout, fifo_rd_commit, fifo_wr_en, fifo_wr_commit;
  logic fifo_wr_abort, event_irq, slow, got_tog;
  logic [1:0] tok_kind, hs_code, hs_last;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_data, tx_data;
  logic [7:0] fifo_rd_data, fifo_wr_data;
  logic [6:0] tx_len, fifo_count, fifo_free, fifo_rd_bytes, got_len, got_bytes;
  logic [5:0] fifo_rd_head;
  logic [11:0] fifo_rd_addr;
  logic [7:0] rxq[$];
  int err_count, num_checks, hs_cnt, wr_cnt, commit_cnt, abort_cnt, rd_cnt;

  // Data is a function of the address, so a wrong start pointer shows.
  assign fifo_rd_data = fifo_rd_addr[7:0] ^ 8'h3c;

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  usb_ctrl_endpoint_txn_control u_usb_ctrl_endpoint_txn_control (
    .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tok_valid, .tok_kind, .rx_valid, .rx_data, .rx_pid_toggle, .rx_end,
    .rx_err, .hs_valid, .hs_code, .tx_start, .tx_len, .tx_toggle,
    .tx_valid, .tx_data, .tx_ready, .host_ack, .host_timeout, .fifo_count,
    .fifo_free, .fifo_rd_head, .fifo_rd_addr, .fifo_rd_data,
    .fifo_rd_commit, .fifo_rd_bytes, .fifo_wr_en, .fifo_wr_data,
    .fifo_wr_commit, .fifo_wr_abort, .event_irq);

  usb_host_model u_usb_host_model (
    .sys_clk, .slow, .tok_valid, .tok_kind, .rx_valid, .rx_data,
    .rx_pid_toggle, .rx_end, .rx_err, .tx_ready, .host_ack, .host_timeout);

  always @(posedge sys_clk) begin
    if (hs_valid) begin
      hs_cnt++;
      hs_last = hs_code;
    end
    if (tx_start) begin
      got_len = tx_len;
      got_tog = tx_toggle;
    end
    if (tx_valid && tx_ready) rxq.push_back(tx_data);
    if (fifo_rd_commit) begin
      rd_cnt++;
      got_bytes = fifo_rd_bytes;
    end
    if (fifo_wr_en) wr_cnt++;
    if (fifo_wr_commit) commit_cnt++;
    if (fifo_wr_abort) abort_cnt++;
  end

  task print_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk) check(reg_rdata, exp);
  endtask : rd

  task hs_chk(input int n, input logic [1:0] code);
    repeat (3) @(posedge sys_clk);
    #1 check(8'(hs_cnt), 8'(n));
    if (n > 0) check(8'(hs_last), 8'(code));
    hs_cnt = 0;
  endtask : hs_chk

  task hs_case(input logic d, input logic [7:0] iv, input logic [7:0] ov,
               input logic [1:0] tok, input logic [1:0] code);
    wr(8'h03, {7'h00, d});
    wr(8'h04, iv);
    wr(8'h05, ov);
    hs_cnt = 0;
    u_usb_host_model.token(tok);
    hs_chk(1, code);
  endtask : hs_case

  task in_xfer(input int n, input logic [11:0] base, input logic tog,
               input logic ok);
    rxq.delete();
    rd_cnt = 0;
    u_usb_host_model.token(usb_ctrl_ep_pkg::TOK_IN);
    for (int i = 0; i < 400 && rxq.size() < n; i++) @(posedge sys_clk);
    if (rxq.size() < n) begin
      err_count++;
      $display("BAD %0t IN data never arrived", $time);
      print_verdict();
    end
    check(8'(got_len), 8'(n));
    check(8'(got_tog), 8'(tog));
    foreach (rxq[i]) check(rxq[i], 8'(base + 12'(i)) ^ 8'h3c);
    u_usb_host_model.answer(ok);
    repeat (3) @(posedge sys_clk);
    check(8'(rxq.size()), 8'(n));
  endtask : in_xfer

  task t_reset;
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
  endtask : t_reset

  task t_setup;
    u_usb_host_model.token(usb_ctrl_ep_pkg::TOK_SETUP);
    u_usb_host_model.packet(7, 1'b0, 1'b0);
    hs_chk(0, usb_ctrl_ep_pkg::HS_ACK);
    rd(8'h00, 8'h00);
    u_usb_host_model.token(usb_ctrl_ep_pkg::TOK_SETUP);
    u_usb_host_model.packet(8, 1'b0, 1'b0);
    hs_chk(1, usb_ctrl_ep_pkg::HS_ACK);
    rd(8'h00, 8'h01);
    for (int i = 0; i < 8; i++) rd(8'h10 + 8'(i), 8'ha0 + 8'(i));
    rd(8'h04, 8'h09);
    rd(8'h05, 8'h09);
    rd(8'h06, 8'h01);
    wr(8'h04, 8'h10);
    rd(8'h04, 8'h09);
    wr(8'h06, 8'h01);
    rd(8'h06, 8'h00);
    wr(8'h04, 8'h04);
    rd(8'h04, 8'h00);
    wr(8'h04, 8'h02);
    rd(8'h04, 8'h01);
  endtask : t_setup

  task t_hand;
    fifo_free <= 7'h40;
    hs_case(1'b1, 8'h08, 8'h00, 2'h2, usb_ctrl_ep_pkg::HS_NAK);
    hs_case(1'b1, 8'h18, 8'h00, 2'h2, usb_ctrl_ep_pkg::HS_STALL);
    hs_case(1'b1, 8'h00, 8'h00, 2'h1, usb_ctrl_ep_pkg::HS_NAK);
    hs_case(1'b0, 8'h00, 8'h08, 2'h1, usb_ctrl_ep_pkg::HS_NAK);
    hs_case(1'b0, 8'h00, 8'h18, 2'h3, usb_ctrl_ep_pkg::HS_STALL);
    hs_case(1'b0, 8'h00, 8'h00, 2'h3, usb_ctrl_ep_pkg::HS_ACK);
    hs_case(1'b0, 8'h00, 8'h10, 2'h1, usb_ctrl_ep_pkg::HS_STALL);
    rd(8'h01, 8'h0c);
    wr(8'h01, 8'h7f);
    rd(8'h01, 8'h00);
  endtask : t_hand

  task t_in;
    fifo_count <= 7'h40;
    wr(8'h03, 8'h01);
    wr(8'h04, 8'h00);
    slow <= 1'b1;
    in_xfer(64, 12'h000, 1'b1, 1'b1);
    check(8'(rd_cnt), 8'h01);
    check(8'(got_bytes), 8'h40);
    rd(8'h04, 8'h00);
    wr(8'h04, 8'h20);
    fifo_count <= 7'h05;
    fifo_rd_head <= 6'h20;
    slow <= 1'b0;
    in_xfer(5, 12'h020, 1'b0, 1'b0);
    in_xfer(5, 12'h020, 1'b0, 1'b1);
    rd(8'h04, 8'h01);
    rd(8'h01, 8'h22);
    hs_case(1'b1, 8'h00, 8'h00, 2'h2, usb_ctrl_ep_pkg::HS_NAK);
  endtask : t_in

  task t_out;
    wr(8'h01, 8'h7f);
    wr(8'h03, 8'h00);
    wr(8'h05, 8'h40);
    u_usb_host_model.token(usb_ctrl_ep_pkg::TOK_OUT);
    u_usb_host_model.packet(10, 1'b1, 1'b0);
    hs_chk(1, usb_ctrl_ep_pkg::HS_ACK);
    check(8'(wr_cnt), 8'h0a);
    check(8'(commit_cnt), 8'h01);
    check(fifo_wr_data, 8'ha9);
    rd(8'h05, 8'h48);
    rd(8'h01, 8'h50);
    wr(8'h05, 8'h40);
    u_usb_host_model.token(usb_ctrl_ep_pkg::TOK_OUT);
    u_usb_host_model.packet(3, 1'b0, 1'b1);
    hs_chk(0, usb_ctrl_ep_pkg::HS_ACK);
    u_usb_host_model.token(usb_ctrl_ep_pkg::TOK_OUT);
    u_usb_host_model.packet(4, 1'b1, 1'b0);
    hs_chk(1, usb_ctrl_ep_pkg::HS_ACK);
    check(8'(abort_cnt), 8'h02);
    check(8'(commit_cnt), 8'h01);
    rd(8'h01, 8'h51);
  endtask : t_out

  task t_desc;
    fifo_count <= 7'h00;
    wr(8'h01, 8'h7f);
    wr(8'h03, 8'h01);
    wr(8'h04, 8'h00);
    wr(8'h07, 8'h01);
    wr(8'h08, 8'h10);
    wr(8'h09, 8'h00);
    wr(8'h0a, 8'h46);
    wr(8'h03, 8'h03);
    in_xfer(64, 12'h110, 1'b1, 1'b1);
    in_xfer(6, 12'h150, 1'b0, 1'b1);
    check(8'(rd_cnt), 8'h00);
    rd(8'h02, 8'h01);
    rd(8'h03, 8'h01);
    rd(8'h08, 8'h56);
  endtask : t_desc

  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, slow} = '0;
    {fifo_count, fifo_free, fifo_rd_head} = '0;
    rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_setup();
    t_hand();
    t_in();
    t_out();
    t_desc();
    print_verdict();
  end
endmodule : test_usb_ctrl_endpoint_txn_control
